// [bench/host_model.sv]
// Host side model: drives the register write strobes and the on code.
// Assumes one clock shared with the block; all changes just after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module host_model (
   // Clock
   input wire logic clk_sys_i,
   // Register strobes and data
   output logic off_time_we_o,
   output logic [7:0] off_time_wdata_o,
   output logic enable_we_o,
   output logic [3:0] enable_wdata_o,
   // Shared on code, a level
   output logic [1:0] sink_on_interval_o
);
   // Idle values at time zero
   initial begin
      off_time_we_o = 1'b0;
      off_time_wdata_o = 8'h00;
      enable_we_o = 1'b0;
      enable_wdata_o = 4'h0;
      sink_on_interval_o = 2'h0;
   end
   // One-cycle strobe; data inverted after so stale values never look valid
   task automatic write_off(input logic [7:0] d);
      @(posedge clk_sys_i);
      off_time_we_o <= 1'b1;
      off_time_wdata_o <= d;
      @(posedge clk_sys_i);
      off_time_we_o <= 1'b0;
      off_time_wdata_o <= ~d;
   endtask
   // Shared on code; a level, changed just after an edge like the strobes
   task automatic set_on(input logic [1:0] c);
      @(posedge clk_sys_i);
      sink_on_interval_o <= c;
   endtask
   // All wanted enables go in a single write
   task automatic write_en(input logic [3:0] d);
      @(posedge clk_sys_i);
      enable_we_o <= 1'b1;
      enable_wdata_o <= d;
      @(posedge clk_sys_i);
      enable_we_o <= 1'b0;
      enable_wdata_o <= ~d;
   endtask
endmodule
`default_nettype wire

// [bench/led_sink_blink_off_timer_bench.sv]
// Self-checking bench for the sink blink off-time block.
// Assumes a short tick parameter so whole blink periods fit in the run.
`timescale 1ns/1ps
`default_nettype none
module led_sink_blink_off_timer_bench;
   localparam int TC = 10; // Clocks per tick, shortened
   logic clk_sys_i = 1'b0;
   logic rst_b_i = 1'b0;
   wire logic owe, ewe;
   wire logic [7:0] owd, ord;
   wire logic [3:0] ewd, en, sink;
   wire logic [1:0] onc;
   int failures = 0;
   int checks_done = 0;
   int cyc = 0;
   int on_t[4] = '{2, 6, 8, 12}; // On ticks per code
   int off_t[4] = '{0, 6, 12, 18}; // Off ticks per code
   // ****************************************
   // Clock, reset, timeout
   // ****************************************
   initial begin
      forever #12.5 clk_sys_i = ~clk_sys_i;
   end
   always @(posedge clk_sys_i) begin
      cyc++;
      if (cyc == 20000) begin
         failures++;
         report_and_stop();
      end
   end
   host_model host (.clk_sys_i(clk_sys_i), .off_time_we_o(owe), .off_time_wdata_o(owd),
      .enable_we_o(ewe), .enable_wdata_o(ewd), .sink_on_interval_o(onc));
   led_sink_blink_off_timer #(.TICK_CYCLES(TC)) DUT (.clk_sys_i(clk_sys_i),
      .rst_b_i(rst_b_i), .off_time_we_i(owe), .off_time_wdata_i(owd),
      .off_time_rdata_o(ord), .enable_we_i(ewe), .enable_wdata_i(ewd),
      .sink_enable_bit_o(en), .sink_on_interval_i(onc), .current_sink_on_o(sink));
   // ****************************************
   // Shared helpers
   // ****************************************
   task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   // Cycles while a sink bit holds the given level, bounded
   task automatic run_len(input int n, input logic lvl, output int len);
      len = 0;
      while (sink[n] === lvl && len < 400) begin
         @(negedge clk_sys_i);
         len++;
      end
   endtask
   // One sink, one off code, one on code: measure a whole off and on period
   task automatic blink_case(input int n, input logic [1:0] on_c, input logic [1:0] off_c);
      int lo, hi;
      host.set_on(on_c);
      host.write_off(8'(off_c) << (2 * n));
      host.write_en(4'h1 << n);
      repeat (4) @(negedge clk_sys_i);
      check({4'h0, en}, 8'h01 << n, "enable readback");
      run_len(n, 1'b1, hi);
      run_len(n, 1'b0, lo);
      check(8'(lo), 8'(off_t[off_c] * TC), "off length");
      run_len(n, 1'b1, hi);
      check(8'(hi), 8'(on_t[on_c] * TC), "on length");
      host.write_en(4'h0);
      repeat (4) @(negedge clk_sys_i);
      check({4'h0, sink}, 8'h00, "disabled sink");
   endtask
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic reset_and_readback();
      check(ord, 8'h00, "off time reset");
      check({en, sink}, 8'h00, "enable and drive reset");
      host.write_off(8'hC9);
      @(negedge clk_sys_i);
      check(ord, 8'hC9, "off time readback");
   endtask
   task automatic steady_on();
      int hi;
      host.write_off(8'h00);
      host.write_en(4'h5);
      repeat (4) @(negedge clk_sys_i);
      check({4'h0, sink}, 8'h05, "steady sinks on");
      run_len(0, 1'b1, hi);
      check(8'(hi == 400), 8'h01, "steady without blinking");
      host.write_en(4'h0);
   endtask
   task automatic lockstep();
      int odd, flips;
      logic [3:0] prev;
      odd = 0;
      flips = 0;
      host.write_off(8'h55);
      host.write_en(4'hF);
      prev = sink;
      repeat (400) begin
         @(negedge clk_sys_i);
         if (sink !== 4'h0 && sink !== 4'hF) odd++;
         // Previous sample kept by hand; sampled-value calls do not belong here
         if (sink !== prev) flips++;
         prev = sink;
      end
      check(8'(odd), 8'h00, "sinks out of step");
      check(8'(flips > 0), 8'h01, "group blinks");
      host.write_en(4'h0);
   endtask
   // Reset in mid-run while all sinks are lit: all state clears, then runs again
   task automatic mid_reset();
      host.write_off(8'hFF);
      host.write_en(4'hF);
      repeat (20) @(negedge clk_sys_i);
      @(posedge clk_sys_i);
      rst_b_i <= 1'b0;
      @(negedge clk_sys_i);
      check(ord, 8'h00, "off time cleared by reset");
      check({en, sink}, 8'h00, "enable and drive cleared by reset");
      repeat (2) @(posedge clk_sys_i);
      rst_b_i <= 1'b1;
      host.write_en(4'h3);
      repeat (4) @(negedge clk_sys_i);
      check({4'h0, sink}, 8'h03, "sinks restart after reset");
      host.write_en(4'h0);
   endtask
   task automatic report_and_stop();
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      repeat (3) @(posedge clk_sys_i);
      rst_b_i <= 1'b1;
      @(negedge clk_sys_i);
      reset_and_readback();
      steady_on();
      for (int n = 0; n < 4; n++) begin
         blink_case(n, 2'(n), 2'(n % 3 + 1));
      end
      blink_case(3, 2'h3, 2'h3);
      lockstep();
      mid_reset();
      report_and_stop();
   end
endmodule
`default_nettype wire

// [verilog/blink_params.svh]
// Constants for the current-sink blink off-time block.
// Assumes a 40 MHz system clock and an internal 0.1 s blink tick.
// Functional notes
// - Sink 4 off time from bits 7:6.
// - Sink 3 off time from bits 5:4.
// - Sink 2 off time from bits 3:2.
// - Sink 1 off time from bits 1:0.
// - Field 00: enabled sink stays on steadily.
// - Non-zero field: alternate off and on intervals.
// - Sinks enabled together start sequences together.
// - Shared on-time code picks 0.2/0.6/0.8/1.2 s.
// - Per-sink enable bit turns sink on/off.
`ifndef BLINK_PARAMS_SVH
`define BLINK_PARAMS_SVH

// ****************************************
// Register layout
// ****************************************
`define OFF_TIME_RESET 8'h00
`define OFF_FIELD_W 2
`define SINK_OFF_LSB(n) (`OFF_FIELD_W * (n))
`define ENABLE_RESET 4'h0

// ****************************************
// Timing
// ****************************************
`define BLINK_CLK_NS 25
`define BLINK_TICK_NS 100000000
`define BLINK_TICK_CYCLES (`BLINK_TICK_NS / `BLINK_CLK_NS)

// Interval lengths in 0.1 s ticks
`define ON_TICKS_00 5'h02
`define ON_TICKS_01 5'h06
`define ON_TICKS_10 5'h08
`define ON_TICKS_11 5'h0C
`define OFF_TICKS_01 5'h06
`define OFF_TICKS_10 5'h0C
`define OFF_TICKS_11 5'h12

`endif

// [verilog/blink_pkg.sv]
// Types for the current-sink blink off-time block.
// Assumes blink_params.svh supplies all numeric constants.
package blink_pkg;
   // Per-sink blink phase, one-hot
   typedef enum logic [2:0] {
      PH_IDLE = 3'b001,
      PH_ON   = 3'b010,
      PH_OFF  = 3'b100
   } phase_type;
endpackage

// [verilog/led_sink_blink_off_timer.sv]
// Blink sequencer for current sinks 1 to 4 with the off-time register.
// Assumes the register interface block drives the write strobes on clk_sys_i.
`timescale 1ns/1ps
`default_nettype none
`include "blink_params.svh"

module led_sink_blink_off_timer
   import blink_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = `BLINK_TICK_CYCLES
) (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_b_i,
   // Off-time register access
   input wire logic off_time_we_i,
   input wire logic [7:0] off_time_wdata_i,
   output logic [7:0] off_time_rdata_o,
   // Enable register access, one bit per sink
   input wire logic enable_we_i,
   input wire logic [3:0] enable_wdata_i,
   output logic [3:0] sink_enable_bit_o,
   // Shared on-time code from the companion timing register
   input wire logic [1:0] sink_on_interval_i,
   // Sink drive
   output logic [3:0] current_sink_on_o
);

   // ****************************************
   // Decoders
   // ****************************************
   // On interval length in ticks
   function automatic logic [4:0] on_ticks(input logic [1:0] code);
      case (code)
         2'h0: on_ticks = `ON_TICKS_00;
         2'h1: on_ticks = `ON_TICKS_01;
         2'h2: on_ticks = `ON_TICKS_10;
         default: on_ticks = `ON_TICKS_11;
      endcase
   endfunction

   // Off interval length in ticks; 00 never reaches here
   function automatic logic [4:0] off_ticks(input logic [1:0] code);
      case (code)
         2'h1: off_ticks = `OFF_TICKS_01;
         2'h2: off_ticks = `OFF_TICKS_10;
         default: off_ticks = `OFF_TICKS_11;
      endcase
   endfunction

   // ****************************************
   // Registers
   // ****************************************
   logic [7:0] off_time_r; // Four 2-bit off-time fields
   logic [7:0] off_time_nxt;
   logic [3:0] en_r; // Per-sink enables
   logic [3:0] en_nxt;
   logic [21:0] div_r; // Tick divider
   logic [21:0] div_nxt;
   logic tick_r; // One-cycle 0.1 s tick
   logic tick_nxt;
   phase_type state_r [4]; // Blink phase per sink
   phase_type state_nxt [4];
   logic [4:0] cnt_r [4]; // Ticks spent in the phase
   logic [4:0] cnt_nxt [4];
   logic [3:0] on_r; // Registered sink drive
   logic [3:0] on_nxt;

   // Field of sink n (0 = sink 1)
   function automatic logic [1:0] field(input logic [7:0] r, input int n);
      field = r[`SINK_OFF_LSB(n) +: `OFF_FIELD_W];
   endfunction

   // Register writes and shared tick
   always_comb begin
      off_time_nxt = off_time_r;
      en_nxt = en_r;
      if (off_time_we_i) begin
         off_time_nxt = off_time_wdata_i;
      end
      if (enable_we_i) begin
         // Whole nibble at once, so sinks set together start together
         en_nxt = enable_wdata_i;
      end
      // Free-running divider; all sinks share it so their edges line up
      if (div_r == 22'(TICK_CYCLES - 1)) begin
         div_nxt = 22'h000000;
         tick_nxt = 1'b1;
      end else begin
         div_nxt = div_r + 22'h000001;
         tick_nxt = 1'b0;
      end
   end

   // Per-sink phase machines
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         state_nxt[i] = state_r[i];
         cnt_nxt[i] = cnt_r[i];
         case (state_r[i])
            PH_IDLE: begin
               cnt_nxt[i] = 5'h00;
               if (en_r[i]) begin
                  // Sequence opens with the on interval
                  state_nxt[i] = PH_ON;
               end
            end
            PH_ON: begin
               if (!en_r[i]) begin
                  state_nxt[i] = PH_IDLE;
                  cnt_nxt[i] = 5'h00;
               end else if (field(off_time_r, i) == 2'h0) begin
                  cnt_nxt[i] = 5'h00; // Steady on
               end else if (tick_r) begin
                  if (cnt_r[i] + 5'h01 >= on_ticks(sink_on_interval_i)) begin
                     state_nxt[i] = PH_OFF;
                     cnt_nxt[i] = 5'h00;
                  end else begin
                     cnt_nxt[i] = cnt_r[i] + 5'h01;
                  end
               end
            end
            PH_OFF: begin
               if (!en_r[i]) begin
                  state_nxt[i] = PH_IDLE;
                  cnt_nxt[i] = 5'h00;
               end else if (field(off_time_r, i) == 2'h0) begin
                  // Blinking switched off mid-interval: go steady on
                  state_nxt[i] = PH_ON;
                  cnt_nxt[i] = 5'h00;
               end else if (tick_r) begin
                  if (cnt_r[i] + 5'h01 >= off_ticks(field(off_time_r, i))) begin
                     state_nxt[i] = PH_ON;
                     cnt_nxt[i] = 5'h00;
                  end else begin
                     cnt_nxt[i] = cnt_r[i] + 5'h01;
                  end
               end
            end
            default: begin
               state_nxt[i] = PH_IDLE;
               cnt_nxt[i] = 5'h00;
            end
         endcase
         on_nxt[i] = (state_nxt[i] == PH_ON);
      end
   end

   // State registers
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         off_time_r <= `OFF_TIME_RESET;
         en_r <= `ENABLE_RESET;
         div_r <= 22'h000000;
         tick_r <= 1'b0;
         on_r <= 4'h0;
         for (int i = 0; i < 4; i++) begin
            state_r[i] <= PH_IDLE;
            cnt_r[i] <= 5'h00;
         end
      end else begin
         off_time_r <= off_time_nxt;
         en_r <= en_nxt;
         div_r <= div_nxt;
         tick_r <= tick_nxt;
         on_r <= on_nxt;
         for (int i = 0; i < 4; i++) begin
            state_r[i] <= state_nxt[i];
            cnt_r[i] <= cnt_nxt[i];
         end
      end
   end

   assign off_time_rdata_o = off_time_r;
   assign sink_enable_bit_o = en_r;
   assign current_sink_on_o = on_r;

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_b_i);

   a_sync_start: assert property (
      (enable_we_i && enable_wdata_i[1:0] == 2'h3 && en_r[1:0] == 2'h0)
      |=> ##1 (state_r[0] == state_r[1] && cnt_r[0] == cnt_r[1]))
      else $error("sinks enabled together are out of step");

   a_tick_single: assert property (tick_r |=> !tick_r)
      else $error("tick lasted more than one cycle");

   for (genvar g = 0; g < 4; g++) begin : g_chk
      sequence s_on_done;
         state_r[g] == PH_ON && en_r[g] && field(off_time_r, g) != 2'h0 && tick_r
         && cnt_r[g] + 5'h01 >= on_ticks(sink_on_interval_i);
      endsequence
      sequence s_off_done;
         state_r[g] == PH_OFF && en_r[g] && field(off_time_r, g) != 2'h0 && tick_r
         && cnt_r[g] + 5'h01 >= off_ticks(field(off_time_r, g));
      endsequence

      a_off_disabled: assert property (!en_r[g] |=> !current_sink_on_o[g])
         else $error("disabled sink is driven");
      a_cnt_cleared: assert property (!en_r[g] |=> cnt_r[g] == 5'h00)
         else $error("counter not cleared while disabled");
      a_steady_on: assert property (
         (en_r[g] && field(off_time_r, g) == 2'h0) |=> current_sink_on_o[g])
         else $error("steady sink not on");
      a_start_on: assert property ($rose(en_r[g]) |=> current_sink_on_o[g])
         else $error("sequence did not open with on interval");
      a_on_expire: assert property (s_on_done |=> !current_sink_on_o[g])
         else $error("on interval did not end on time");
      a_off_expire: assert property (
         s_off_done |=> current_sink_on_o[g])
         else $error("off interval did not end on time");
      a_off_holds: assert property (
         (state_r[g] == PH_OFF && en_r[g] && !tick_r && field(off_time_r, g) != 2'h0)
         |=> (state_r[g] == PH_OFF && $stable(cnt_r[g])))
         else $error("off interval left without a tick");
   end

endmodule

`default_nettype wire
